// [pgc_pkg.sv]
// Purpose: Constants shared by the peripheral clock gate control block.
// Assumes: Four 16-bit gate control registers at word indices 0 to 3.
// Notes:   Flat gate index is register index times 16 plus bit position.
package pgc_pkg;

  localparam int REG_W    = 16;
  localparam int NUM_REGS = 4;
  localparam int ADDR_W   = 2;
  localparam int GATE_W   = REG_W * NUM_REGS;

  typedef logic [REG_W-1:0]  reg_t;
  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [GATE_W-1:0] gate_t;

  // Register word indices
  localparam addr_t GATE_CTRL_1_IDX = 2'h0;
  localparam addr_t GATE_CTRL_2_IDX = 2'h1;
  localparam addr_t GATE_CTRL_3_IDX = 2'h2;
  localparam addr_t GATE_CTRL_4_IDX = 2'h3;

  // First control register fields
  localparam int TIMER5_GATE_OFF_POS           = 15;
  localparam int TIMER4_GATE_OFF_POS           = 14;
  localparam int TIMER3_GATE_OFF_POS           = 13;
  localparam int TIMER2_GATE_OFF_POS           = 12;
  localparam int TIMER1_GATE_OFF_POS           = 11;
  localparam int QUAD_DECODER1_GATE_OFF_POS    = 10;
  localparam int PULSE_WIDTH_UNIT_GATE_OFF_POS = 9;
  localparam int TWO_WIRE1_GATE_OFF_POS        = 7;
  localparam int SERIAL_PORT2_GATE_OFF_POS     = 6;
  localparam int SERIAL_PORT1_GATE_OFF_POS     = 5;
  localparam int SYNC_SERIAL2_GATE_OFF_POS     = 4;
  localparam int SYNC_SERIAL1_GATE_OFF_POS     = 3;
  localparam int CAN_CTRL_GATE_OFF_POS         = 1;
  localparam int CONVERTER_GATE_OFF_POS        = 0;
  // Second control register fields
  localparam int CAPTURE4_GATE_OFF_POS         = 11;
  localparam int CAPTURE3_GATE_OFF_POS         = 10;
  localparam int CAPTURE2_GATE_OFF_POS         = 9;
  localparam int CAPTURE1_GATE_OFF_POS         = 8;
  localparam int COMPARE4_GATE_OFF_POS         = 3;
  localparam int COMPARE3_GATE_OFF_POS         = 2;
  localparam int COMPARE2_GATE_OFF_POS         = 1;
  localparam int COMPARE1_GATE_OFF_POS         = 0;
  // Third control register fields
  localparam int COMPARATOR_GATE_OFF_POS       = 10;
  localparam int QUAD_DECODER2_GATE_OFF_POS    = 5;
  localparam int TWO_WIRE2_GATE_OFF_POS        = 1;
  // Fourth control register field
  localparam int REF_CLOCK_OUT_GATE_OFF_POS    = 3;

  localparam reg_t ONE = 16'h0001;

  localparam reg_t GATE_CTRL_1_MASK =
    (ONE << TIMER5_GATE_OFF_POS) | (ONE << TIMER4_GATE_OFF_POS) |
    (ONE << TIMER3_GATE_OFF_POS) | (ONE << TIMER2_GATE_OFF_POS) |
    (ONE << TIMER1_GATE_OFF_POS) | (ONE << QUAD_DECODER1_GATE_OFF_POS) |
    (ONE << PULSE_WIDTH_UNIT_GATE_OFF_POS) |
    (ONE << TWO_WIRE1_GATE_OFF_POS) | (ONE << SERIAL_PORT2_GATE_OFF_POS) |
    (ONE << SERIAL_PORT1_GATE_OFF_POS) | (ONE << SYNC_SERIAL2_GATE_OFF_POS) |
    (ONE << SYNC_SERIAL1_GATE_OFF_POS) | (ONE << CAN_CTRL_GATE_OFF_POS) |
    (ONE << CONVERTER_GATE_OFF_POS);
  localparam reg_t GATE_CTRL_2_MASK =
    (ONE << CAPTURE4_GATE_OFF_POS) | (ONE << CAPTURE3_GATE_OFF_POS) |
    (ONE << CAPTURE2_GATE_OFF_POS) | (ONE << CAPTURE1_GATE_OFF_POS) |
    (ONE << COMPARE4_GATE_OFF_POS) | (ONE << COMPARE3_GATE_OFF_POS) |
    (ONE << COMPARE2_GATE_OFF_POS) | (ONE << COMPARE1_GATE_OFF_POS);
  localparam reg_t GATE_CTRL_3_MASK =
    (ONE << COMPARATOR_GATE_OFF_POS) | (ONE << QUAD_DECODER2_GATE_OFF_POS) |
    (ONE << TWO_WIRE2_GATE_OFF_POS);
  localparam reg_t GATE_CTRL_4_MASK = ONE << REF_CLOCK_OUT_GATE_OFF_POS;

  localparam reg_t GATE_CTRL_1_RESET = 16'h0000;
  localparam reg_t GATE_CTRL_2_RESET = 16'h0000;
  localparam reg_t GATE_CTRL_3_RESET = 16'h0000;
  localparam reg_t GATE_CTRL_4_RESET = 16'h0000;

  localparam gate_t IMPL_FLAT = {GATE_CTRL_4_MASK, GATE_CTRL_3_MASK,
                                 GATE_CTRL_2_MASK, GATE_CTRL_1_MASK};
  localparam gate_t RESET_FLAT = {GATE_CTRL_4_RESET, GATE_CTRL_3_RESET,
                                  GATE_CTRL_2_RESET, GATE_CTRL_1_RESET};

  // One instruction cycle equals one system clock cycle here
  localparam int INSTR_CYCLE_NS = 10;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int GATE_DELAY_CYC = (INSTR_CYCLE_NS / CLK_PERIOD_NS < 1) ? 1 :
                                  INSTR_CYCLE_NS / CLK_PERIOD_NS;

endpackage : pgc_pkg

// [pgc_delay_pipe.sv]
// Purpose: Fixed-depth delay line for the gate-off vector.
// Assumes: Same clock as the register file; DEPTH of at least one.
// Notes:   Every stage resets to zero, so peripherals start enabled.
`timescale 1ns/1ps
module pgc_delay_pipe #(
  parameter int W     = 64,
  parameter int DEPTH = 1
) (
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [DEPTH-1:0][W-1:0] stage_reg;
  logic [DEPTH-1:0][W-1:0] stage_next;

  always_comb
  begin
    stage_next = stage_reg;
    if (ce_i)
    begin
      stage_next[0] = d_i;
      for (int i = 1; i < DEPTH; i++)
      begin
        stage_next[i] = stage_reg[i-1];
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      stage_reg <= '0;
    end
    else
    begin
      stage_reg <= stage_next;
    end
  end

  assign q_o = stage_reg[DEPTH-1];

endmodule : pgc_delay_pipe

// [pgc_gate_cell.sv]
// Purpose: Clock enable and register access gate for one peripheral.
// Assumes: gate_off_i already carries the one instruction cycle delay.
// Notes:   An absent peripheral is held off whatever its bit holds.
`timescale 1ns/1ps
module pgc_gate_cell #(
  parameter bit PRESENT = 1'b1
) (
  input  wire logic gate_off_i,
  input  wire logic periph_wr_i,
  output logic      clk_en_o,
  output logic      wr_o,
  output logic      rd_valid_o
);

  always_comb
  begin
    clk_en_o   = PRESENT & ~gate_off_i;
    // Writes to a stopped peripheral are dropped here
    wr_o       = periph_wr_i & clk_en_o;
    rd_valid_o = clk_en_o;
  end

endmodule : pgc_gate_cell

// [pgc_top.sv]
// Purpose: Peripheral clock gate control with four gate control registers.
// Assumes: Register port on CLK_SYS_I; peripheral strobes on the same clock.
// Notes:   Gate outputs are clock enables for downstream clock gate cells.
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module pgc_top #(
  parameter pgc_pkg::gate_t PRESENT_MASK = pgc_pkg::IMPL_FLAT
) (
  input  wire logic           CLK_SYS_I,
  input  wire logic           SRST_I,
  input  wire logic           CE_I,
  input  wire pgc_pkg::addr_t REG_ADDR_I,
  input  wire pgc_pkg::reg_t  REG_WDATA_I,
  input  wire logic           REG_WR_I,
  input  wire logic           REG_RD_I,
  output pgc_pkg::reg_t       REG_RDATA_O,
  input  wire pgc_pkg::gate_t PERIPH_WR_I,
  output pgc_pkg::gate_t      PERIPH_WR_O,
  output pgc_pkg::gate_t      PERIPH_CLK_EN_O,
  output pgc_pkg::gate_t      PERIPH_RD_VALID_O
);
  import pgc_pkg::*;

  localparam logic [NUM_REGS-1:0][REG_W-1:0] IMPL_MASKS = IMPL_FLAT;
  localparam logic [NUM_REGS-1:0][REG_W-1:0] RESET_VALS = RESET_FLAT;

  logic [NUM_REGS-1:0][REG_W-1:0] ctrl_reg;
  logic [NUM_REGS-1:0][REG_W-1:0] ctrl_next;
  reg_t                           rdata_reg;
  reg_t                           rdata_next;
  gate_t                          gate_flat;
  gate_t                          gate_dly;

  // Register file: a read in the same cycle as a write returns the value held before that write
  always_comb
  begin
    ctrl_next  = ctrl_reg;
    rdata_next = '0;
    if (CE_I)
    begin
      if (REG_WR_I)
      begin
        // field layout 1, field layout 2
        // field layout 3, field layout 4
        ctrl_next[REG_ADDR_I] = REG_WDATA_I & IMPL_MASKS[REG_ADDR_I];
      end
      if (REG_RD_I)
      begin
        rdata_next = ctrl_reg[REG_ADDR_I] & IMPL_MASKS[REG_ADDR_I];
      end
    end
    else
    begin
      rdata_next = rdata_reg;
    end
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (SRST_I)
    begin
      ctrl_reg  <= RESET_VALS;
      rdata_reg <= '0;
    end
    else
    begin
      ctrl_reg  <= ctrl_next;
      rdata_reg <= rdata_next;
    end
  end

  assign REG_RDATA_O = rdata_reg;
  assign gate_flat   = ctrl_reg;

  // one cycle disable delay, one cycle enable delay
  pgc_delay_pipe #(
    .W     (GATE_W),
    .DEPTH (GATE_DELAY_CYC)
  ) u_delay (
    .clk_i  (CLK_SYS_I),
    .srst_i (SRST_I),
    .ce_i   (CE_I),
    .d_i    (gate_flat),
    .q_o    (gate_dly)
  );

  // Unimplemented positions get no cell, so their outputs stay low
  wire [GATE_W-1:0] cell_clk_en;
  wire [GATE_W-1:0] cell_wr;
  wire [GATE_W-1:0] cell_rd_valid;

  for (genvar g = 0; g < GATE_W; g++)
  begin : g_gate
    if (IMPL_FLAT[g])
    begin : g_cell
      // present and clear, absent stays off
      pgc_gate_cell #(
        .PRESENT (PRESENT_MASK[g])
      ) u_cell (
        .gate_off_i  (gate_dly[g]),
        .periph_wr_i (PERIPH_WR_I[g]),
        .clk_en_o    (cell_clk_en[g]),
        .wr_o        (cell_wr[g]),
        .rd_valid_o  (cell_rd_valid[g])
      );
    end
    else
    begin : g_none
      assign cell_clk_en[g]   = 1'b0;
      assign cell_wr[g]       = 1'b0;
      assign cell_rd_valid[g] = 1'b0;
    end
  end

  // Per-bit drivers meet on nets, so each port has a single driver
  assign PERIPH_CLK_EN_O   = cell_clk_en;
  assign PERIPH_WR_O       = cell_wr;
  assign PERIPH_RD_VALID_O = cell_rd_valid;

  // Helper state for the checks below
  logic  past_valid_reg;
  logic  past_valid_next;
  reg_t  wr_mask_reg;
  reg_t  wr_mask_next;
  addr_t wr_addr_reg;
  addr_t wr_addr_next;
  logic  wr_seen_reg;
  logic  wr_seen_next;

  always_comb
  begin
    past_valid_next = past_valid_reg;
    wr_mask_next    = wr_mask_reg;
    wr_addr_next    = wr_addr_reg;
    wr_seen_next    = wr_seen_reg;
    // Frozen with the gate bits, so a held write still matches them
    if (CE_I)
    begin
      past_valid_next = 1'b1;
      wr_mask_next    = REG_WDATA_I & IMPL_MASKS[REG_ADDR_I];
      wr_addr_next    = REG_ADDR_I;
      wr_seen_next    = REG_WR_I;
    end
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (SRST_I)
    begin
      past_valid_reg <= 1'b0;
      wr_mask_reg    <= '0;
      wr_addr_reg    <= '0;
      wr_seen_reg    <= 1'b0;
    end
    else
    begin
      past_valid_reg <= past_valid_next;
      wr_mask_reg    <= wr_mask_next;
      wr_addr_reg    <= wr_addr_next;
      wr_seen_reg    <= wr_seen_next;
    end
  end

  property p_gate_follows;
    @(posedge CLK_SYS_I) disable iff (SRST_I)
      (past_valid_reg && $past(CE_I)) |->
        PERIPH_CLK_EN_O == (PRESENT_MASK & IMPL_FLAT & ~$past(gate_flat));
  endproperty
  a_gate_follows: assert property (p_gate_follows)
    else $error("Clock enable does not follow gate bits by one cycle");

  property p_disable_delay;
    @(posedge CLK_SYS_I) disable iff (SRST_I)
      (CE_I && REG_WR_I && REG_ADDR_I == GATE_CTRL_1_IDX &&
       REG_WDATA_I[TIMER1_GATE_OFF_POS] ##1 CE_I) |->
        ##1 !PERIPH_CLK_EN_O[TIMER1_GATE_OFF_POS];
  endproperty
  a_disable_delay: assert property (p_disable_delay)
    else $error("Timer 1 clock still enabled after gate-off");

  property p_enable_delay;
    @(posedge CLK_SYS_I) disable iff (SRST_I)
      (CE_I && REG_WR_I && REG_ADDR_I == GATE_CTRL_4_IDX &&
       !REG_WDATA_I[REF_CLOCK_OUT_GATE_OFF_POS] ##1 CE_I) |->
        ##1 PERIPH_CLK_EN_O[GATE_W-REG_W+REF_CLOCK_OUT_GATE_OFF_POS] ==
            PRESENT_MASK[GATE_W-REG_W+REF_CLOCK_OUT_GATE_OFF_POS];
  endproperty
  a_enable_delay: assert property (p_enable_delay)
    else $error("Reference clock not enabled one cycle after clear");

  property p_write_blocked;
    @(posedge CLK_SYS_I) disable iff (SRST_I)
      (PERIPH_WR_O & ~PERIPH_CLK_EN_O) == '0 &&
      PERIPH_WR_O == (PERIPH_WR_I & PERIPH_CLK_EN_O);
  endproperty
  a_write_blocked: assert property (p_write_blocked)
    else $error("Peripheral write passed while disabled");

  property p_rd_valid;
    @(posedge CLK_SYS_I) disable iff (SRST_I)
      PERIPH_RD_VALID_O == PERIPH_CLK_EN_O;
  endproperty
  a_rd_valid: assert property (p_rd_valid)
    else $error("Read valid differs from clock enable");

  property p_absent_off;
    @(posedge CLK_SYS_I) disable iff (SRST_I)
      (PERIPH_CLK_EN_O & ~(PRESENT_MASK & IMPL_FLAT)) == '0;
  endproperty
  a_absent_off: assert property (p_absent_off)
    else $error("Absent peripheral shows a clock enable");

  property p_reset_clear;
    @(posedge CLK_SYS_I)
      SRST_I |=> (gate_flat == RESET_FLAT && REG_RDATA_O == '0);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("Gate bits not cleared by reset");

  property p_reset_enabled;
    @(posedge CLK_SYS_I)
      SRST_I ##1 SRST_I |=> PERIPH_CLK_EN_O == (PRESENT_MASK & IMPL_FLAT);
  endproperty
  a_reset_enabled: assert property (p_reset_enabled)
    else $error("Present peripherals not enabled after reset");

  property p_unimpl_zero;
    @(posedge CLK_SYS_I) disable iff (SRST_I)
      (CE_I && REG_RD_I) |=>
        (REG_RDATA_O & ~IMPL_MASKS[$past(REG_ADDR_I)]) == '0;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("Unimplemented register bit read as one");

  property p_readback;
    @(posedge CLK_SYS_I) disable iff (SRST_I)
      (wr_seen_reg && CE_I && REG_RD_I && REG_ADDR_I == wr_addr_reg) |=>
        REG_RDATA_O == $past(wr_mask_reg);
  endproperty
  a_readback: assert property (p_readback)
    else $error("Read data differs from masked written value");

  property p_rdata_idle;
    @(posedge CLK_SYS_I) disable iff (SRST_I)
      (CE_I && !REG_RD_I) |=> REG_RDATA_O == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("Read data not zero outside the read answer cycle");

  property p_freeze;
    @(posedge CLK_SYS_I) disable iff (SRST_I)
      (!CE_I && !SRST_I) |=>
        ($stable(PERIPH_CLK_EN_O) && $stable(gate_flat));
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("State changed while clock enable low");

  property p_rdata_hold;
    @(posedge CLK_SYS_I) disable iff (SRST_I)
      (!CE_I && !SRST_I) |=> $stable(REG_RDATA_O);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("Read data changed while clock enable low");

  property p_pwm_off;
    @(posedge CLK_SYS_I) disable iff (SRST_I)
      (CE_I && REG_WR_I && REG_ADDR_I == GATE_CTRL_1_IDX &&
       REG_WDATA_I[PULSE_WIDTH_UNIT_GATE_OFF_POS] ##1 CE_I) |->
        ##1 !PERIPH_CLK_EN_O[PULSE_WIDTH_UNIT_GATE_OFF_POS];
  endproperty
  a_pwm_off: assert property (p_pwm_off)
    else $error("Pulse width unit clock still on after gate-off");

  property p_unimpl_store;
    @(posedge CLK_SYS_I) disable iff (SRST_I)
      (gate_flat & ~IMPL_FLAT) == '0;
  endproperty
  a_unimpl_store: assert property (p_unimpl_store)
    else $error("Unimplemented gate bit stored as one");

  property p_write_lands;
    @(posedge CLK_SYS_I) disable iff (SRST_I)
      wr_seen_reg |-> ctrl_reg[wr_addr_reg] == wr_mask_reg;
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("Written gate bits not stored under the field mask");

  c_disable: cover property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    $fell(PERIPH_CLK_EN_O[PULSE_WIDTH_UNIT_GATE_OFF_POS]));
  c_reenable: cover property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    $rose(PERIPH_CLK_EN_O[PULSE_WIDTH_UNIT_GATE_OFF_POS]));
  c_wr_dropped: cover property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    (PERIPH_WR_I & ~PERIPH_CLK_EN_O) != '0);
  c_readback: cover property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    wr_seen_reg && CE_I && REG_RD_I && REG_ADDR_I == wr_addr_reg);

endmodule : pgc_top

// [test_pgc_top.sv]
// Purpose: Self-checking bench for the peripheral clock gate control block.
// Assumes: Register strobes one cycle; read data in the next cycle only.
// Notes:   Model runs on the same edges as the block; compared every cycle.
`timescale 1ns/1ps
module test_pgc_top;
  import pgc_pkg::*;

  // Timer three absent, so its enable must never rise
  localparam gate_t PRESENT = IMPL_FLAT & ~64'h2000;

  logic  clk;
  logic  srst;
  logic  ce;
  addr_t reg_addr;
  reg_t  reg_wdata;
  logic  reg_wr;
  logic  reg_rd;
  reg_t  reg_rdata;
  gate_t periph_wr_in;
  gate_t periph_wr_out;
  gate_t clk_en;
  gate_t rd_valid;

  reg_t        model [4];
  reg_t        rd_exp;
  gate_t       en_exp;
  logic        armed;
  logic        pwm_rewrite;
  logic [31:0] seed;
  logic [31:0] wr_seed;
  int          fails;
  int          n_checks;

  pgc_top #(
    .PRESENT_MASK (PRESENT)
  ) dut (
    .CLK_SYS_I         (clk),
    .SRST_I            (srst),
    .CE_I              (ce),
    .REG_ADDR_I        (reg_addr),
    .REG_WDATA_I       (reg_wdata),
    .REG_WR_I          (reg_wr),
    .REG_RD_I          (reg_rd),
    .REG_RDATA_O       (reg_rdata),
    .PERIPH_WR_I       (periph_wr_in),
    .PERIPH_WR_O       (periph_wr_out),
    .PERIPH_CLK_EN_O   (clk_en),
    .PERIPH_RD_VALID_O (rd_valid)
  );

  always #5 clk = ~clk;

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic tally_and_finish();
    if (fails == 0 && n_checks > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic cmp16(input reg_t got, input reg_t exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp16

  task automatic cmp64(input gate_t got, input gate_t exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp64

  // One bus cycle: op 0 idle, 1 write, 2 read
  task automatic bus(input int op, input addr_t a, input reg_t d,
                     input logic c);
    @(posedge clk);
    ce        <= c;
    reg_wr    <= (op == 1);
    reg_rd    <= (op == 2);
    reg_addr  <= a;
    reg_wdata <= d;
  endtask : bus

  // Enable follows the stored bit one edge late, so sample before writing
  always @(posedge clk)
  begin
    if (srst)
    begin
      model  = '{default: '0};
      rd_exp = '0;
      en_exp = IMPL_FLAT & PRESENT;
      armed  = 1'b1;
    end
    else if (ce)
    begin
      en_exp = ~{model[3], model[2], model[1], model[0]} & IMPL_FLAT
               & PRESENT;
      rd_exp = reg_rd ? model[reg_addr] : '0;
      if (reg_wr)
        model[reg_addr] = reg_wdata & IMPL_FLAT[reg_addr*16 +: 16];
    end
  end

  // Peripheral-side write strobes keep changing to expose the write gate
  always @(posedge clk)
  begin
    wr_seed = lfsr_next(wr_seed);
    periph_wr_in <= {wr_seed, ~wr_seed} | (pwm_rewrite ? 64'h200 : 64'h0);
  end

  always @(negedge clk)
  begin
    if (armed)
    begin
      cmp16(reg_rdata, rd_exp);
      cmp64(clk_en, en_exp);
      cmp64(rd_valid, en_exp);
      cmp64(periph_wr_out, periph_wr_in & en_exp);
    end
  end

  initial
  begin
    #50000;
    fails++;
    tally_and_finish();
  end

  initial
  begin
    clk          = 1'b0;
    srst         = 1'b1;
    ce           = 1'b1;
    reg_addr     = '0;
    reg_wdata    = '0;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    periph_wr_in = '0;
    pwm_rewrite  = 1'b0;
    armed        = 1'b0;
    fails        = 0;
    n_checks     = 0;
    seed         = 32'hEE2201D8;
    wr_seed      = 32'hEE2201D8;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    // Reset values read back first
    for (int a = 0; a < 4; a++)
      bus(2, addr_t'(a), '0, 1'b1);
    // All ones then all zeros, read straight after each write
    for (int a = 0; a < 4; a++)
    begin
      bus(1, addr_t'(a), 16'hFFFF, 1'b1);
      bus(2, addr_t'(a), '0, 1'b1);
      bus(1, addr_t'(a), 16'h0000, 1'b1);
      bus(2, addr_t'(a), '0, 1'b1);
    end
    // Walking one over every flat position, absent timer included
    for (int i = 0; i < 64; i++)
    begin
      bus(1, addr_t'(i / 16), ONE << (i % 16), 1'b1);
      bus(2, addr_t'(i / 16), '0, 1'b1);
      bus(0, '0, '0, 1'b1);
      bus(1, addr_t'(i / 16), 16'h0000, 1'b1);
    end
    // Pulse width unit off and on, then its registers rewritten
    bus(1, GATE_CTRL_1_IDX, 16'h0200, 1'b1);
    bus(1, GATE_CTRL_1_IDX, 16'h0000, 1'b1);
    bus(0, '0, '0, 1'b1);
    pwm_rewrite <= 1'b1;
    repeat (3) bus(0, '0, '0, 1'b1);
    pwm_rewrite <= 1'b0;
    // Random traffic with the clock enable dropping now and then
    repeat (300)
    begin
      seed = lfsr_next(seed);
      bus(seed[1:0] == 2'h3 ? 0 : int'(seed[1:0]), addr_t'(seed[3:2]),
          seed[31:16], seed[7:4] != 4'h0);
    end
    // Reset in mid-run clears every stored bit
    bus(1, GATE_CTRL_1_IDX, 16'hFFFF, 1'b1);
    bus(1, GATE_CTRL_3_IDX, 16'hFFFF, 1'b1);
    bus(0, '0, '0, 1'b1);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    for (int a = 0; a < 4; a++)
      bus(2, addr_t'(a), '0, 1'b1);
    repeat (3) bus(0, '0, '0, 1'b1);
    tally_and_finish();
  end

endmodule : test_pgc_top
